// ---- include/led_pkg.sv ----
`default_nettype none
package led_pkg;
	// Function codes selected per pin.
	localparam logic [3:0] FN_LINK_ANY = 4'h0;
	localparam logic [3:0] FN_GIG_LINK_WITH_ACTIVITY = 4'h1;
	localparam logic [3:0] FN_FAST_LINK_WITH_ACTIVITY = 4'h2;
	localparam logic [3:0] FN_TEN_LINK_WITH_ACTIVITY = 4'h3;
	localparam logic [3:0] FN_LINK_100_1000 = 4'h4;
	localparam logic [3:0] FN_LINK_10_1000 = 4'h5;
	localparam logic [3:0] FN_LINK_10_100 = 4'h6;
	localparam logic [3:0] FN_DUPLEX_COLLISION = 4'h8;
	localparam logic [3:0] FN_COLLISION = 4'h9;
	localparam logic [3:0] FN_ACTIVITY = 4'ha;
	localparam logic [3:0] FN_AUTONEG_FAULT = 4'hc;
	localparam logic [3:0] FN_FORCE_OFF = 4'he;
	localparam logic [3:0] FN_FORCE_ON = 4'hf;
	// Pin levels: the pins are active low.
	localparam logic PIN_ON = 1'b0;
	localparam logic PIN_OFF = 1'b1;
	// Timing figures.
	localparam int CLK_HZ = 100_000_000;
	localparam int BASE_MS = 50;
	localparam int BLINK_BASE_DHZ = 25;
	localparam int PULSING_HZ = 5_000;
	localparam int PULSING_DUTY_PCT = 20;
	localparam int STRETCH_BASE_CYC = CLK_HZ / 1000 * BASE_MS;
	localparam int BLINK_BASE_HALF_CYC = CLK_HZ * 10 / BLINK_BASE_DHZ / 2;
	localparam int PULSING_PERIOD_CYC = CLK_HZ / PULSING_HZ;
	localparam int PULSING_ON_CYC = PULSING_PERIOD_CYC * PULSING_DUTY_PCT / 100;
endpackage
`default_nettype wire

// ---- src/led_status_driver.sv ----
// Function
// - Code 0: on with link at any speed.
// - Code 1: on with gigabit link only.
// - Code 2: on with 100 Mb/s link.
// - Code 3: on with 10 Mb/s link.
// - Code 4: on with 100 or 1000 link.
// - Code 5: on with 10 or 1000 link.
// - Code 6: on with 10 or 100 link.
// - Link codes: activity blinks pin toward off.
// - Code 8: full duplex on, half-duplex collisions blink.
// - Code 9: collisions blink pin on.
// - Code 10: activity blinks; select bit means transmit.
// - Code 12: on while auto-negotiation fault present.
// - Code 14 forced off, 15 forced on.
// - Combine: link asserts, activity blinks too.
// - Combine disable shows primary function only, except codes 9 and 10, which still blink.
// - Per-pin choice of blink or stretch.
// - Blink has equal high and low times.
// - Per-pin rate: four blink rates, stretch lengths.
// - Stretch holds full period, minimum half period off.
// - Pulsing modulates asserted pin 5 kHz, 20%.
// - Power-down forces every pin off.
`timescale 1ns/1ps
`default_nettype none

module led_status_driver
	import led_pkg::*;
#(
	parameter int PINS = 2,
	parameter int STRETCH_BASE = led_pkg::STRETCH_BASE_CYC,
	parameter int BLINK_HALF_BASE = led_pkg::BLINK_BASE_HALF_CYC,
	parameter int PULSING_PERIOD = led_pkg::PULSING_PERIOD_CYC,
	parameter int PULSING_ON = led_pkg::PULSING_ON_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic link_1000,
	input wire logic link_100,
	input wire logic link_10,
	input wire logic full_duplex,
	input wire logic tx_activity,
	input wire logic rx_activity,
	input wire logic collision,
	input wire logic autoneg_fault,
	input wire logic power_down,
	input wire logic activity_tx_only,
	input wire logic pulsing_enable,
	input wire logic [4*PINS-1:0] function_code,
	input wire logic [PINS-1:0] combine_disable,
	input wire logic [PINS-1:0] stretch_enable,
	input wire logic [2*PINS-1:0] rate_select,
	output logic [PINS-1:0] led_n
);
	import led_pkg::*;

	// Blink rates are the slowest rate times one, two, four and eight.
	localparam int BLINK_STEPS = 8;
	localparam int DIV_BITS = 4;
	localparam int SW = $clog2(STRETCH_BASE * BLINK_STEPS + 1);
	localparam int BW = $clog2(BLINK_HALF_BASE + 1);
	localparam int PW = $clog2(PULSING_PERIOD + 1);

	// ==========================================================
	// Shared time bases
	// ==========================================================
	// One blink prescaler feeds all pins; the fastest rate (20 Hz) toggles
	// bit 0 of a divider and slower rates use higher bits, so pins stay in phase.
	// Bit 3 of the divider is the slowest rate (2.5 Hz).
	// Sharing one divider costs a little phase freedom but keeps two pins
	// that show the same rate blinking together, which looks deliberate.
	logic [BW-1:0] blink_cnt_q, blink_cnt_d;
	logic [DIV_BITS-1:0] blink_div_q, blink_div_d;
	logic [PW-1:0] pulsing_cnt_q, pulsing_cnt_d;

	always_comb
	begin
		blink_cnt_d = blink_cnt_q;
		blink_div_d = blink_div_q;
		pulsing_cnt_d = pulsing_cnt_q;
		if (clk_en)
		begin
			if (blink_cnt_q >= BW'(BLINK_HALF_BASE / BLINK_STEPS - 1))
			begin
				blink_cnt_d = '0;
				blink_div_d = blink_div_q + DIV_BITS'(1);
			end
			else
				blink_cnt_d = blink_cnt_q + BW'(1);
			if (pulsing_cnt_q >= PW'(PULSING_PERIOD - 1))
				pulsing_cnt_d = '0;
			else
				pulsing_cnt_d = pulsing_cnt_q + PW'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			blink_cnt_q <= '0;
			blink_div_q <= '0;
			pulsing_cnt_q <= '0;
		end
		else
		begin
			blink_cnt_q <= blink_cnt_d;
			blink_div_q <= blink_div_d;
			pulsing_cnt_q <= pulsing_cnt_d;
		end
	end

	// Pulsing on-phase is the first fifth of each 5 kHz period.
	logic pulse_phase;
	assign pulse_phase = pulsing_cnt_q < PW'(PULSING_ON);

	logic any_activity;
	assign any_activity = tx_activity | rx_activity;

	// ==========================================================
	// Per-pin indicator logic
	// ==========================================================
	// Each pin has a primary level, a qualifier that allows the secondary
	// indication, and an event input. Blink gates the event with the shared
	// wave; stretch turns each event into a timed pulse from its own counter.
	// Link codes show the secondary indication by turning the pin off, while
	// the duplex, collision and activity codes turn it on.
	// Power-down and pulsing are applied last, so they override any function.
	// A limitation: a single short event in blink mode only shows if it falls
	// in the active half of the wave, which is why stretch exists.
	// The pins leave flip-flops so that no decode glitch reaches a lamp.
	logic [PINS-1:0] led_q, led_d;
	logic [SW-1:0] stretch_cnt_q [PINS];
	logic [SW-1:0] stretch_cnt_d [PINS];
	logic [PINS-1:0] stretch_act_q, stretch_act_d;

	always_comb
	begin
		logic [3:0] code;
		logic [1:0] rate;
		logic primary;
		logic qual;
		logic event_in;
		logic blink_wave;
		logic indicate;
		logic toward_off;
		logic lit;
		logic [SW-1:0] period;
		code = '0;
		rate = '0;
		primary = 1'b0;
		qual = 1'b0;
		event_in = 1'b0;
		blink_wave = 1'b0;
		indicate = 1'b0;
		toward_off = 1'b0;
		lit = 1'b0;
		period = '0;
		led_d = led_q;
		for (int i = 0; i < PINS; i++)
		begin
			stretch_cnt_d[i] = stretch_cnt_q[i];
			stretch_act_d[i] = stretch_act_q[i];
			code = function_code[4*i +: 4];
			rate = rate_select[2*i +: 2];
			primary = 1'b0;
			qual = 1'b0;
			event_in = 1'b0;
			toward_off = 1'b0;
			unique case (code)
				FN_LINK_ANY: primary = link_1000 | link_100 | link_10;
				FN_GIG_LINK_WITH_ACTIVITY: primary = link_1000;
				FN_FAST_LINK_WITH_ACTIVITY: primary = link_100;
				FN_TEN_LINK_WITH_ACTIVITY: primary = link_10;
				FN_LINK_100_1000: primary = link_100 | link_1000;
				FN_LINK_10_1000: primary = link_10 | link_1000;
				FN_LINK_10_100: primary = link_10 | link_100;
				FN_DUPLEX_COLLISION:
				begin
					primary = (link_1000 | link_100 | link_10) & full_duplex;
					qual = (link_1000 | link_100 | link_10) & ~full_duplex;
					event_in = collision;
				end
				FN_COLLISION:
				begin
					qual = 1'b1;
					event_in = collision;
				end
				FN_ACTIVITY:
				begin
					qual = 1'b1;
					event_in = activity_tx_only ? tx_activity : any_activity;
				end
				FN_AUTONEG_FAULT: primary = autoneg_fault;
				FN_FORCE_OFF: primary = 1'b0;
				FN_FORCE_ON: primary = 1'b1;
				default: primary = 1'b0;
			endcase
			if (code <= FN_LINK_10_100)
			begin
				qual = primary;
				event_in = any_activity;
				toward_off = 1'b1;
			end
			if (combine_disable[i] && code != FN_COLLISION && code != FN_ACTIVITY)
				qual = 1'b0;
			// Stretch length doubles per rate step: 50, 100, 200, 400 ms.
			period = SW'(STRETCH_BASE) << rate;
			// Rate 0 is the fastest blink, so it takes the lowest divider bit.
			blink_wave = blink_div_q[rate];
			if (clk_en)
			begin
				// Re-triggers hold the pulse; after it ends, a half-period dead
				// time keeps the pin at its base level before the next pulse.
				if (stretch_cnt_q[i] != '0)
					stretch_cnt_d[i] = stretch_cnt_q[i] - SW'(1);
				if (stretch_act_q[i] && stretch_cnt_q[i] == SW'(1))
				begin
					stretch_act_d[i] = 1'b0;
					stretch_cnt_d[i] = period >> 1;
				end
				else if (!stretch_act_q[i] && stretch_cnt_q[i] == '0 && qual && event_in)
				begin
					stretch_act_d[i] = 1'b1;
					stretch_cnt_d[i] = period;
				end
				else if (stretch_act_q[i] && qual && event_in && stretch_cnt_q[i] < (period >> 1))
					stretch_cnt_d[i] = stretch_cnt_q[i] + (period >> 1);
			end
			if (stretch_enable[i])
				indicate = stretch_act_q[i];
			else
				indicate = qual & event_in & blink_wave;
			lit = primary;
			if (qual && indicate)
				lit = ~toward_off;
			if (power_down)
				lit = 1'b0;
			if (pulsing_enable && !pulse_phase)
				lit = 1'b0;
			if (clk_en)
				led_d[i] = lit ? PIN_ON : PIN_OFF;
		end
	end

	// ==========================================================
	// Pin and stretch registers
	// ==========================================================
	// Reset leaves every lamp dark until the first enabled edge.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			led_q <= {PINS{PIN_OFF}};
			stretch_act_q <= '0;
			for (int i = 0; i < PINS; i++)
				stretch_cnt_q[i] <= '0;
		end
		else
		begin
			led_q <= led_d;
			stretch_act_q <= stretch_act_d;
			for (int i = 0; i < PINS; i++)
				stretch_cnt_q[i] <= stretch_cnt_d[i];
		end
	end

	assign led_n = led_q;
endmodule // led_status_driver

`default_nettype wire

// ---- verification/led_lamp.sv ----
`timescale 1ns/1ps
`default_nettype none
module led_lamp
	import led_pkg::*;
(
	input wire logic clk_sys,
	input wire logic clear,
	input wire logic [1:0] led_n,
	output logic [7:0] lit0,
	output logic [7:0] lit1
);
	// A lamp glows only while its pin is pulled low; count those cycles.
	always_ff @(posedge clk_sys)
	begin
		lit0 <= clear ? 8'h00 : lit0 + 8'(led_n[0] == PIN_ON);
		lit1 <= clear ? 8'h00 : lit1 + 8'(led_n[1] == PIN_ON);
	end
endmodule // led_lamp
`default_nettype wire

// ---- verification/led_status_driver_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module led_status_driver_asserts
	import led_pkg::*;
#(
	parameter int PINS = 2
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic link_1000,
	input wire logic link_100,
	input wire logic link_10,
	input wire logic full_duplex,
	input wire logic autoneg_fault,
	input wire logic power_down,
	input wire logic pulsing_enable,
	input wire logic [4*PINS-1:0] function_code,
	input wire logic [PINS-1:0] combine_disable,
	input wire logic [PINS-1:0] led_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire go = clk_en && !power_down && !pulsing_enable;
	wire [3:0] c0 = function_code[3:0];
	wire [3:0] c1 = function_code[7:4];
	wire [6:0] q = {link_10 | link_100, link_10 | link_1000, link_100 | link_1000,
		link_10, link_100, link_1000, link_10 | link_100 | link_1000};
	// Three lit cycles at most: two of modulation plus one of register lag.
	sequence s_lit4;
		(pulsing_enable && clk_en && led_n[0] == PIN_ON)[*4];
	endsequence
	AST_FREEZE: assert property (!clk_en |=> $stable(led_n)) else $error("pins moved while frozen");
	AST_POWER_DOWN: assert property (clk_en && power_down |=> &led_n) else $error("pin lit in power-down");
	AST_FORCE_OFF: assert property (clk_en && c0 == FN_FORCE_OFF |=> led_n[0]) else $error("forced off lit");
	AST_FORCE_ON: assert property (go && c0 == FN_FORCE_ON |=> !led_n[0]) else $error("forced on dark");
	AST_RESERVED: assert property (clk_en && c0 inside {4'h7, 4'hb, 4'hd} |=> led_n[0]) else $error("reserved lit");
	AST_LINK: assert property (go && combine_disable[1] && c1 < 4'h7 |=> led_n[1] == !$past(q[c1[2:0]]))
		else $error("link pin wrong");
	AST_DUPLEX: assert property (go && combine_disable[1] && c1 == FN_DUPLEX_COLLISION
		|=> led_n[1] == !$past(full_duplex && q[0])) else $error("duplex pin wrong");
	AST_AN_FAULT: assert property (go && c0 == FN_AUTONEG_FAULT |=> led_n[0] == !$past(autoneg_fault))
		else $error("fault pin wrong");
	AST_PULSING: assert property (not s_lit4) else $error("pulsed pin lit too long");
endmodule // led_status_driver_asserts
bind led_status_driver led_status_driver_asserts #(.PINS(PINS)) i_led_status_driver_asserts (.clk_sys,
	.rst, .clk_en, .link_1000, .link_100, .link_10, .full_duplex, .autoneg_fault, .power_down,
	.pulsing_enable, .function_code, .combine_disable, .led_n);
`default_nettype wire

// ---- verification/tb_enhanced_led_status_driver.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_enhanced_led_status_driver;
	import led_pkg::*;
	logic clk_sys, rst, clk_en, link_1000, link_100, link_10, full_duplex, tx_activity;
	logic rx_activity, collision, autoneg_fault, power_down, activity_tx_only, pulsing_enable, clear;
	logic [7:0] function_code, lit0, lit1;
	logic [1:0] combine_disable, stretch_enable, led_n, last;
	logic [3:0] rate_select;
	logic [31:0] seed = 32'h63572e70;
	logic [1:0] exp_q[$];
	int bad_count = 0;
	int samples_checked = 0;
	led_status_driver #(.PINS(2), .STRETCH_BASE(64), .BLINK_HALF_BASE(64), .PULSING_PERIOD(10),
		.PULSING_ON(2)) i_led_status_driver (.clk_sys, .rst, .clk_en, .link_1000, .link_100,
		.link_10, .full_duplex, .tx_activity, .rx_activity, .collision, .autoneg_fault, .power_down,
		.activity_tx_only, .pulsing_enable, .function_code, .combine_disable, .stretch_enable,
		.rate_select, .led_n);
	led_lamp i_led_lamp (.clk_sys, .clear, .led_n, .lit0, .lit1);
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic pin(logic [3:0] c);
		logic [6:0] q;
		q = {link_10 | link_100, link_10 | link_1000, link_100 | link_1000, link_10, link_100,
			link_1000, link_10 | link_100 | link_1000};
		if (power_down) return PIN_OFF;
		if (c < 4'h7) return !q[c[2:0]];
		if (c == FN_DUPLEX_COLLISION) return !(full_duplex && q[0]);
		if (c == FN_AUTONEG_FAULT) return !autoneg_fault;
		return c != FN_FORCE_ON;
	endfunction
	task automatic check(logic [8:0] seen, logic [8:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
			bad_count++;
		end
	endtask
	task automatic test_done;
		$display("%0d mismatches in %0d comparisons", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// The lamp counts lit cycles over a span, so blink and stretch are judged by duty.
	task automatic span(int n);
		clear = 1;
		@(negedge clk_sys);
		clear = 0;
		repeat (n) @(negedge clk_sys);
	endtask
	initial
	begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#100us;
		bad_count++;
		test_done();
	end
	always @(posedge clk_sys)
	begin
		#1;
		if (exp_q.size() > 0)
			check(9'(led_n), 9'(exp_q.pop_front()));
	end
	initial
	begin
		{rst, clk_en, clear, last, combine_disable, stretch_enable} = 9'h1fe;
		{link_1000, link_100, link_10, full_duplex, tx_activity, rx_activity, collision} = '0;
		{autoneg_fault, power_down, activity_tx_only, pulsing_enable} = '0;
		function_code = '0;
		rate_select = '0;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 0;
		for (int i = 0; i < 128; i++)
		begin
			seed = lfsr(seed);
			{link_1000, link_100, link_10, full_duplex, autoneg_fault} = seed[4:0];
			power_down = &seed[6:5];
			clk_en = |seed[9:7];
			function_code = {seed[13:10], 4'(i)};
			if (clk_en) last = {pin(function_code[7:4]), pin(function_code[3:0])};
			exp_q.push_back(last);
			@(negedge clk_sys);
		end
		{power_down, clk_en, activity_tx_only, link_1000, link_100, link_10} = 6'h1a;
		combine_disable = 2'b00;
		function_code = {FN_ACTIVITY, FN_LINK_ANY};
		tx_activity = 1;
		span(160);
		check(9'(lit0 >= 8'd72 && lit0 <= 8'd88), 9'h001);
		tx_activity = 0;
		repeat (300) @(negedge clk_sys);
		tx_activity = 1;
		@(negedge clk_sys);
		tx_activity = 0;
		span(200);
		check(9'(lit1 >= 8'd64 && lit1 <= 8'd96), 9'h001);
		function_code = {FN_ACTIVITY, FN_FORCE_ON};
		{pulsing_enable, rx_activity} = 2'b11;
		span(100);
		check(9'(lit0), 9'h014);
		check(9'(lit1), 9'h000);
		test_done();
	end
endmodule // tb_enhanced_led_status_driver
`default_nettype wire
